//--- ext_bus_if.sv
// external bus interface: strobes, port muxing, arbitration, reset filter
`timescale 1ns/10ps
`default_nettype none
module external_bus_interface
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_reset_pin_n,
   input wire logic i_alt_bus_select,
   input wire logic i_ext_access_n,
   input wire logic [ext_bus_pkg::NUM_REQ-1:0] i_req,
   input wire logic [ext_bus_pkg::NUM_REQ-1:0] i_req_wr,
   input wire logic [ext_bus_pkg::NUM_REQ-1:0] i_req_code,
   input wire logic [47:0] i_req_addr,
   input wire logic [23:0] i_req_wdata,
   input wire logic [7:0] i_p0_in,
   input wire logic [7:0] i_p5_in,
   input wire logic [7:0] i_p0_gpio,
   input wire logic [7:0] i_p2_gpio,
   input wire logic [7:0] i_p5_gpio,
   input wire logic [7:0] i_p6_gpio,
   output logic [ext_bus_pkg::NUM_REQ-1:0] o_grant,
   output logic [ext_bus_pkg::NUM_REQ-1:0] o_done,
   output logic [7:0] o_rdata,
   output logic o_core_reset,
   output logic o_ale,
   output logic o_prim_fetch_strobe_n,
   output logic o_alt_fetch_strobe_n,
   output logic o_data_rd_n,
   output logic o_data_wr_n,
   output logic [7:0] o_p0_out,
   output logic [7:0] o_p0_oe,
   output logic [7:0] o_p2_out,
   output logic [7:0] o_p5_out,
   output logic [7:0] o_p5_oe,
   output logic [7:0] o_p6_out
);
   import ext_bus_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; first stage read only by second
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [7:0] p0s1_reg, p0s2_reg, p5s1_reg, p5s2_reg;
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
         p0s1_reg <= 8'h00;
         p0s2_reg <= 8'h00;
         p5s1_reg <= 8'h00;
         p5s2_reg <= 8'h00;
      end
      else
      begin
         sync1_reg <= {i_reset_pin_n, i_alt_bus_select, i_ext_access_n};
         sync2_reg <= sync1_reg;
         p0s1_reg <= i_p0_in;
         p0s2_reg <= p0s1_reg;
         p5s1_reg <= i_p5_in;
         p5s2_reg <= p5s1_reg;
      end
   end
   wire rst_pin_n = sync2_reg[2];
   wire alt_sel = sync2_reg[1];
   wire ext_acc_n = sync2_reg[0];

   ////////////////////////////////////////////////////////////////////////
   // reset filter: pin low a full three machine cycles
   // o_core_reset is held high and the sequencer starts no new access; serial channel is not touched
   logic [7:0] rst_cnt_reg;
   logic core_reset_reg;
   wire rst_full = (rst_cnt_reg == 8'(RST_CLKS));
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         rst_cnt_reg <= 8'h00;
      else if (rst_pin_n)
         rst_cnt_reg <= 8'h00;
      else if (!rst_full)
         rst_cnt_reg <= rst_cnt_reg + 8'h01;
   end
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         core_reset_reg <= 1'b1;
      else
         core_reset_reg <= rst_full;
   end
   assign o_core_reset = core_reset_reg;

   ////////////////////////////////////////////////////////////////////////
   // fixed priority grant: dma0, dma1, then cpu core; one at a time
   wire [1:0] pick = i_req[1] ? GRANT_DMA0 :
                     i_req[2] ? GRANT_DMA1 : GRANT_CPU;
   // alternate bus used only when select is high and fetches are external
   wire use_alt = alt_sel & ~ext_acc_n;

   ////////////////////////////////////////////////////////////////////////
   // access sequencer: address, latch pulse, strobe, done
   bus_state_t st_reg, st_next;
   logic [1:0] own_reg;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic wr_reg, code_reg, alt_reg, wait_reg;
   // done waits a second edge so read data has cleared the pin synchroniser
   wire last = (st_reg == ST_DONE) && wait_reg;
   wire [15:0] sel_addr = i_req_addr[16*pick +: 16];
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         ST_IDLE: if (|i_req && !core_reset_reg) st_next = ST_ADDR;
         ST_ADDR: st_next = ST_LATCH;
         ST_LATCH: st_next = ST_STROBE;
         ST_STROBE: st_next = ST_DONE;
         ST_DONE: if (wait_reg) st_next = ST_IDLE;
         default: st_next = ST_IDLE;
      endcase
   end
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_reg <= ST_IDLE;
         own_reg <= GRANT_CPU;
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
         wait_reg <= 1'b0;
         wr_reg <= 1'b0;
         code_reg <= 1'b0;
         alt_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         if (st_reg == ST_IDLE)
         begin
            own_reg <= pick;
            addr_reg <= sel_addr;
            wdata_reg <= i_req_wdata[8*pick +: 8];
            wr_reg <= i_req_wr[pick] & ~i_req_code[pick];
            code_reg <= i_req_code[pick];
            alt_reg <= use_alt;
         end
         wait_reg <= (st_reg == ST_DONE) && !wait_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next values of the pin outputs
   wire busy = (st_reg != ST_IDLE) && (st_reg != ST_DONE);
   wire strobe = (st_next == ST_STROBE);
   wire in_addr = (st_next == ST_ADDR) || (st_next == ST_LATCH);
   wire prim = busy && !alt_reg;
   wire altb = busy && alt_reg;
   wire [7:0] lo_next = in_addr ? addr_reg[7:0] : wdata_reg;
   wire lo_drive = in_addr || (strobe && wr_reg);
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ale <= 1'b0;
         o_prim_fetch_strobe_n <= 1'b1;
         o_alt_fetch_strobe_n <= 1'b1;
         o_data_rd_n <= 1'b1;
         o_data_wr_n <= 1'b1;
         o_p0_out <= 8'h00;
         o_p0_oe <= 8'h00;
         o_p2_out <= 8'h00;
         o_p5_out <= 8'h00;
         o_p5_oe <= 8'h00;
         o_p6_out <= 8'h00;
         o_grant <= 3'h0;
         o_done <= 3'h0;
         o_rdata <= 8'h00;
      end
      else
      begin
         o_ale <= (st_next == ST_LATCH);
         o_prim_fetch_strobe_n <= ~(strobe && code_reg && !alt_reg);
         o_alt_fetch_strobe_n <= ~(strobe && code_reg && alt_reg);
         o_data_rd_n <= ~(strobe && !code_reg && !wr_reg);
         o_data_wr_n <= ~(strobe && wr_reg);
         o_p0_out <= prim ? lo_next : i_p0_gpio;
         o_p0_oe <= (prim ? lo_drive : 1'b0) ? 8'hff : ~i_p0_gpio;
         o_p2_out <= prim ? addr_reg[15:8] : i_p2_gpio;
         o_p5_out <= altb ? lo_next : i_p5_gpio;
         o_p5_oe <= (altb && lo_drive) ? 8'hff : 8'h00;
         o_p6_out <= altb ? addr_reg[15:8] : i_p6_gpio;
         o_grant <= (st_reg == ST_IDLE) ? 3'h0 : 3'(1 << own_reg);
         o_done <= last ? 3'(1 << own_reg) : 3'h0;
         if (last && !wr_reg)
            o_rdata <= alt_reg ? p5s2_reg : p0s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_grant_onehot: assert property (@(posedge i_mclk) disable iff (i_rst)
      $onehot0(o_grant)) else $error("more than one bus owner");
   a_latch_before: assert property (@(posedge i_mclk) disable iff (i_rst)
      $fell(o_ale) |-> $fell(o_data_rd_n) || $fell(o_data_wr_n)
      || $fell(o_prim_fetch_strobe_n) || $fell(o_alt_fetch_strobe_n))
      else $error("strobe not right after latch");
   a_latch_width: assert property (@(posedge i_mclk) disable iff (i_rst)
      $rose(o_ale) |=> !o_ale) else $error("latch pulse too long");
   a_strobe_excl: assert property (@(posedge i_mclk) disable iff (i_rst)
      !(!o_prim_fetch_strobe_n && !o_alt_fetch_strobe_n))
      else $error("both fetch strobes low");
   a_rdwr_excl: assert property (@(posedge i_mclk) disable iff (i_rst)
      !(!o_data_rd_n && !o_data_wr_n)) else $error("rd and wr low");
   a_reset_filter: assert property (@(posedge i_mclk) disable iff (i_rst)
      $rose(o_core_reset) |-> $past(rst_cnt_reg) == 8'(RST_CLKS))
      else $error("reset too early");
   a_alt_route: assert property (@(posedge i_mclk) disable iff (i_rst)
      !o_alt_fetch_strobe_n |-> o_p2_out == i_p2_gpio ||
      $past(i_p2_gpio) == o_p2_out) else $error("port 2 used on alt");
   a_done_after: assert property (@(posedge i_mclk) disable iff (i_rst)
      $rose(o_ale) |-> ##4 (o_done != 3'h0))
      else $error("access did not finish");
endmodule
`default_nettype wire

//--- ext_bus_pkg.sv
// constants shared by the external bus interface
// Behaviour
// - alternate bus selected: program reads use the alternate fetch strobe
// - primary bus selected: program reads use the primary fetch strobe
// - bus select and external access input pick ports 0/2 or 5/6
// - latch strobe pulses so the external latch holds the low address
// - primary bus: open-drain port 0 carries multiplexed low byte
// - reset only after reset pin sampled low three machine cycles
// - reset need not abort a serial channel transmission in progress
// - one shared bus, granted to exactly one requester at a time
// - two dma channels move 8-bit data at 16-bit addresses
// - primary bus: port 2 carries the high address byte
// - alternate bus: port 5 low byte, port 6 high byte
// - separate active-low data read and write strobes on port 3
package ext_bus_pkg;
   localparam int MCLK_HZ = 100_000_000;
   localparam int MACH_CYCLE_NS = 120;
   localparam int MACH_CYC_CLKS = (MACH_CYCLE_NS * (MCLK_HZ / 1_000_000))
      / 1000;
   localparam int RST_MACH_CYCLES = 3;
   localparam int RST_CLKS = RST_MACH_CYCLES * MACH_CYC_CLKS;
   localparam int NUM_REQ = 3;
   localparam logic [1:0] GRANT_CPU = 2'h0;
   localparam logic [1:0] GRANT_DMA0 = 2'h1;
   localparam logic [1:0] GRANT_DMA1 = 2'h2;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_ADDR = 5'h02,
      ST_LATCH = 5'h04,
      ST_STROBE = 5'h08,
      ST_DONE = 5'h10
   } bus_state_t;
endpackage

//--- ext_mem_model.sv
// external program and data memory with its address latch
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model
(
   input wire logic i_mclk,
   input wire logic [7:0] i_lo_out,
   input wire logic [7:0] i_lo_oe,
   input wire logic [7:0] i_hi_out,
   input wire logic i_ale,
   input wire logic i_fetch_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   output logic [7:0] o_lo_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] lat_reg;
   // released bits float to the pull-up level
   wire [7:0] bus_lo = i_lo_out | ~i_lo_oe;
   wire [15:0] adr = {i_hi_out, lat_reg};
   wire rd_on = !i_rd_n || !i_fetch_n;
   // program space is a fixed pattern so no preload is needed
   wire [7:0] rd_val = !i_fetch_n ? (adr[7:0] ^ adr[15:8]) : mem[adr];
   // memory lets go of the bus as soon as its strobe rises
   assign o_lo_in = rd_on ? rd_val : bus_lo;
   // latch loads on a clock edge while the strobe is high; a late strobe leaves a stale address
   always_ff @(posedge i_mclk)
   begin
      if (i_ale) lat_reg <= bus_lo;
      if (!i_wr_n) mem[adr] <= bus_lo;
   end
endmodule
`default_nettype wire

//--- external_bus_interface_tb.sv
// self-checking bench for the external bus interface
`timescale 1ns/10ps
`default_nettype none
module external_bus_interface_tb;
   import ext_bus_pkg::*;
   logic i_mclk = 0, i_rst = 1, i_reset_pin_n = 1;
   logic i_alt_bus_select = 0, i_ext_access_n = 1;
   logic [2:0] i_req = 0, i_req_wr = 0, i_req_code = 0;
   logic [47:0] i_req_addr = 0;
   logic [23:0] i_req_wdata = 0;
   logic [7:0] i_p0_gpio = 0, i_p2_gpio = 0, i_p5_gpio = 0, i_p6_gpio = 0;
   logic [7:0] i_p0_in, i_p5_in, lo_in, d;
   logic [15:0] a;
   logic [2:0] o_grant, o_done;
   logic [7:0] o_rdata, o_p0_out, o_p0_oe, o_p2_out, o_p5_out, o_p5_oe;
   logic [7:0] o_p6_out;
   logic o_core_reset, o_ale, o_prim_fetch_strobe_n, o_alt_fetch_strobe_n;
   logic o_data_rd_n, o_data_wr_n, saw_p = 0, saw_a = 0;
   int fails = 0, n_checks = 0, cyc = 0, seed = 32'h5491da7e;
   logic [13:0] q[$];
   logic [13:0] e;
   wire use_alt = i_alt_bus_select & ~i_ext_access_n;
   always #5 i_mclk = ~i_mclk;
   external_bus_interface dut (.i_mclk, .i_rst, .i_reset_pin_n,
      .i_alt_bus_select, .i_ext_access_n, .i_req, .i_req_wr, .i_req_code,
      .i_req_addr, .i_req_wdata, .i_p0_in, .i_p5_in, .i_p0_gpio, .i_p2_gpio,
      .i_p5_gpio, .i_p6_gpio, .o_grant, .o_done, .o_rdata, .o_core_reset,
      .o_ale, .o_prim_fetch_strobe_n, .o_alt_fetch_strobe_n, .o_data_rd_n,
      .o_data_wr_n, .o_p0_out, .o_p0_oe, .o_p2_out, .o_p5_out, .o_p5_oe,
      .o_p6_out);
   // only the selected bus reaches the memory; the idle one is pulled up
   ext_mem_model mem (.i_mclk, .i_lo_out(use_alt ? o_p5_out : o_p0_out),
      .i_lo_oe(use_alt ? o_p5_oe : o_p0_oe),
      .i_hi_out(use_alt ? o_p6_out : o_p2_out), .i_ale(o_ale),
      .i_fetch_n(use_alt ? o_alt_fetch_strobe_n : o_prim_fetch_strobe_n),
      .i_rd_n(o_data_rd_n), .i_wr_n(o_data_wr_n), .o_lo_in(lo_in));
   assign i_p0_in = use_alt ? (o_p0_out | ~o_p0_oe) : lo_in;
   assign i_p5_in = use_alt ? lo_in : (o_p5_out | ~o_p5_oe);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // note owner, read flag and fetch strobe expected for one access
   function automatic void put(int r, logic w, logic c, logic [7:0] v);
      q.push_back({use_alt, c, !w, 3'(1 << r), v});
   endfunction
   // request held until its done pulse or 40 cycles, then dropped
   task automatic go(int r, logic w, logic c, logic [15:0] ad, logic [7:0] v);
      @(negedge i_mclk);
      i_req_wr[r] = w;
      i_req_code[r] = c;
      i_req_addr[16*r +: 16] = ad;
      i_req_wdata[8*r +: 8] = v;
      i_req[r] = 1;
      for (int k = 0; k < 40 && o_done[r] !== 1'b1; k++)
         @(negedge i_mclk);
      i_req[r] = 0;
   endtask
   // cycle ceiling; a hang ends in the closing report as a failure
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         fails++;
         complete_run();
      end
   end
   // result watcher; strobes are seen a few edges before the done pulse
   always @(posedge i_mclk)
   begin
      if (!o_prim_fetch_strobe_n) saw_p = 1;
      if (!o_alt_fetch_strobe_n) saw_a = 1;
      if (o_done != 0)
      begin
         e = q.pop_front();
         chk(o_done, e[10:8]);
         chk(o_grant, e[10:8]);
         if (e[11]) chk(o_rdata, e[7:0]);
         if (e[12]) chk({saw_a, saw_p}, {e[13], !e[13]});
         saw_p = 0;
         saw_a = 0;
      end
   end
   initial
   begin
      {i_p0_gpio, i_p2_gpio, i_p5_gpio, i_p6_gpio} = $random(seed);
      repeat (5) @(negedge i_mclk);
      i_rst = 0;
      repeat (10) @(negedge i_mclk);
      for (int m = 0; m < 4; m++)
      begin
         {i_alt_bus_select, i_ext_access_n} = m[1:0];
         repeat (4) @(negedge i_mclk);
         if (use_alt) chk(o_p0_oe, 8'(~i_p0_gpio));
         if (use_alt) chk(o_p2_out, i_p2_gpio);
         if (!use_alt) chk(o_p6_out, i_p6_gpio);
         for (int r = 0; r < 3; r++)
         begin
            a = 16'($random(seed));
            d = 8'($random(seed));
            put(r, 1, 0, d);
            go(r, 1, 0, a, d);
            put(r, 0, 0, d);
            go(r, 0, 0, a, d);
            put(r, 0, 1, a[7:0] ^ a[15:8]);
            go(r, 0, 1, a, 8'h00);
         end
      end
      // all three at once: dma0, then dma1, then the core
      put(1, 1, 0, 0);
      put(2, 1, 0, 0);
      put(0, 1, 0, 0);
      fork
         go(0, 1, 0, 16'h0102, 8'h11);
         go(1, 1, 0, 16'h0304, 8'h22);
         go(2, 1, 0, 16'h0506, 8'h33);
      join
      i_reset_pin_n = 0;
      repeat (20) @(negedge i_mclk);
      i_reset_pin_n = 1;
      repeat (5) @(negedge i_mclk);
      chk(o_core_reset, 0);
      i_reset_pin_n = 0;
      repeat (45) @(negedge i_mclk);
      chk(o_core_reset, 1);
      i_reset_pin_n = 1;
      repeat (10) @(negedge i_mclk);
      chk(o_core_reset, 0);
      chk(16'(q.size()), 16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
